// file: pkg/psupc_consts.svh
// offsets, field positions, reset values and timing counts of the protection sequencer
`ifndef PSUPC_CONSTS_SVH
`define PSUPC_CONSTS_SVH
// clock and millisecond tick
`define PSUPC_CLK_HZ        125000000
`define PSUPC_MS_CYC        (`PSUPC_CLK_HZ / 1000)
// times in milliseconds, and the width of the tick counters
`define PSUPC_T_ON_MIN_MS   5
`define PSUPC_T_ON_MAX_MS   400
`define PSUPC_T_PG_MIN_MS   100
`define PSUPC_T_OPP_MS      3
`define PSUPC_MSW           9
// tick counts, least times rounded up by one tick
`define PSUPC_ON_TICKS      9'd6
`define PSUPC_ON_MAX_TICKS  9'd400
`define PSUPC_PG_TICKS      9'd101
`define PSUPC_OPP_TICKS     9'd3
// register byte offsets
`define PSUPC_OFF_CTRL      8'h00
`define PSUPC_OFF_STATUS    8'h04
`define PSUPC_OFF_ADDR      8'h08
// control fields
`define PSUPC_CTRL_FORCE    0
`define PSUPC_CTRL_SWOFF    1
`define PSUPC_CTRL_RST      2'h0
// bus addresses
`define PSUPC_REC_BASE      8'ha0
`define PSUPC_MGT_BASE      8'hb0
// synchronised pin vector positions
`define PSUPC_P_ON_N        0
`define PSUPC_P_S0          1
`define PSUPC_P_S1          2
`define PSUPC_P_SCL         3
`define PSUPC_P_SDA         4
`define PSUPC_P_OC          5
`define PSUPC_P_SC          6
`define PSUPC_P_OPP         7
`define PSUPC_P_RATE        8
`define PSUPC_P_ACOK        9
`define PSUPC_P_SBF         10
`define PSUPC_P_WARN        11
`define PSUPC_P_REG         12
`define PSUPC_NPINS         13
// synchroniser reset value: idle level of every pin
`define PSUPC_PIN_RST       13'h021f
`endif

// file: pkg/psupc_pkg.sv
// types of the protection sequencer
package psupc_pkg;
  // main output sequence
  typedef enum logic [2:0] {SQ_OFF, SQ_DELAY, SQ_WREG, SQ_PGW, SQ_ON, SQ_FAIL} psupc_seq_t;
  // bus target address phase
  typedef enum logic [1:0] {TG_IDLE, TG_ADDR, TG_ACK, TG_SKIP} psupc_tgt_t;
endpackage : psupc_pkg

// file: core/psupc_top.sv
// protection latch, output sequencer, alert and bus target of the power module
//
// Chosen here: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ns
`include "psupc_consts.svh"
module psupc_top #(
  parameter int P_MS_CYC = `PSUPC_MS_CYC  // clock cycles per millisecond tick
) (
  input  wire logic        i_ref_clk,          // 125 MHz clock
  input  wire logic        i_rst_n,            // standby power arrival, async low
  input  wire logic        i_remote_on_input_n,// on request, low active
  input  wire logic        i_addr_strap_bit0,  // strap pin, pulled up
  input  wire logic        i_addr_strap_bit1,  // strap pin, pulled up
  input  wire logic        i_scl,              // bus clock level
  input  wire logic        i_sda,              // bus data level
  output logic             o_sda,              // bus data drive value
  output logic             o_sda_oe,           // bus data pull low enable
  input  wire logic        i_overcurrent_trip, // main over limit
  input  wire logic        i_short_circuit_trip,// main short
  input  wire logic        i_overpower_trip,   // load above overpower point
  input  wire logic        i_above_rating,     // load above rated power
  input  wire logic        i_ac_ok,            // input power present
  input  wire logic        i_sb_fault,         // standby over current or short
  input  wire logic        i_warn,             // temp, failure, ov, uv, fan, oc warning
  input  wire logic        i_main_in_reg,      // main output within regulation
  output logic             o_main_en,          // main output enable
  output logic             o_sb_en,            // standby output enable
  output logic             o_pwr_good,         // power good, high is good
  output logic             o_alert,            // alert drive value
  output logic             o_alert_oe,         // alert pull low enable
  output logic             o_led_amber,        // amber indicator
  input  wire logic        hclk_unused_n,      // tie high; keeps port order stable
  input  wire logic        hsel,               // ahb slave select
  input  wire logic [7:0]  haddr,              // ahb byte address
  input  wire logic [1:0]  htrans,             // ahb transfer type
  input  wire logic        hwrite,             // ahb write
  input  wire logic [2:0]  hsize,              // ahb size
  input  wire logic [31:0] hwdata,             // ahb write data
  input  wire logic        hready,             // ahb bus ready
  output logic             hreadyout,          // ahb slave ready
  output logic             hresp,              // ahb response
  output logic [31:0]      hrdata              // ahb read data
);

  // pin synchroniser inputs and outputs
  logic [`PSUPC_NPINS-1:0] pin_raw;
  logic [`PSUPC_NPINS-1:0] pin_m_r;            // first stage, read by second only
  logic [`PSUPC_NPINS-1:0] pin_r;              // second stage
  localparam logic [`PSUPC_NPINS-1:0] PIN_RST = `PSUPC_PIN_RST;  // idle levels, no false edge after reset
  assign pin_raw = {i_main_in_reg, i_warn, i_sb_fault, i_ac_ok, i_above_rating,
                    i_overpower_trip, i_short_circuit_trip, i_overcurrent_trip,
                    i_sda, i_scl, i_addr_strap_bit1, i_addr_strap_bit0, i_remote_on_input_n};

  // two flops per pin
  genvar g;
  generate
    for (g = 0; g < `PSUPC_NPINS; g++) begin : g_sync
      always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          pin_m_r[g] <= PIN_RST[g];
          pin_r[g]   <= PIN_RST[g];
        end else begin
          pin_m_r[g] <= pin_raw[g];
          pin_r[g]   <= pin_m_r[g];
        end
      end
    end
  endgenerate

  logic req_on;                                // request active
  logic ac_ok;                                 // input power present
  assign req_on = ~pin_r[`PSUPC_P_ON_N];
  assign ac_ok  = pin_r[`PSUPC_P_ACOK];

  // millisecond tick divider
  logic [31:0] div_r;
  logic        tick;
  assign tick = (div_r == 32'(P_MS_CYC - 1));
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_r <= 32'h0;
    end else if (tick) begin
      div_r <= 32'h0;
    end else begin
      div_r <= div_r + 32'h1;
    end
  end

  // request history for re-activation edge
  logic req_d_r;
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      req_d_r <= 1'b0;
    end else begin
      req_d_r <= req_on;
    end
  end

  // overpower persistence counter in ticks
  logic [`PSUPC_MSW-1:0] opp_cnt_r;
  logic                  opp_trip;
  assign opp_trip = (opp_cnt_r >= `PSUPC_OPP_TICKS);
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      opp_cnt_r <= '0;
    end else if (!pin_r[`PSUPC_P_OPP]) begin
      opp_cnt_r <= '0;
    end else if (tick && !opp_trip) begin
      opp_cnt_r <= opp_cnt_r + 1'b1;
    end
  end

  // protection fault latch, set beats clear
  logic fault_r;
  logic fault_set;
  logic fault_clr;
  assign fault_set = pin_r[`PSUPC_P_OC] | pin_r[`PSUPC_P_SC] | opp_trip;
  assign fault_clr = (req_on & ~req_d_r) | ~ac_ok;
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fault_r <= 1'b0;
    end else if (fault_set) begin
      fault_r <= 1'b1;
    end else if (fault_clr) begin
      fault_r <= 1'b0;
    end
  end

  // standby follows its own fault with no latch
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_sb_en <= 1'b0;
    end else begin
      o_sb_en <= ~pin_r[`PSUPC_P_SBF];
    end
  end

  // software control register
  logic [1:0] ctrl_r;
  logic       run_ok;                          // conditions to keep main on
  assign run_ok = req_on & ac_ok & ~fault_r & ~fault_set & ~ctrl_r[`PSUPC_CTRL_SWOFF];

  // main output sequencer
  psupc_pkg::psupc_seq_t seq_r;
  logic [`PSUPC_MSW-1:0] seq_cnt_r;            // ticks in current state
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      seq_r     <= psupc_pkg::SQ_OFF;
      seq_cnt_r <= '0;
    end else if (!run_ok) begin
      seq_r     <= (fault_r | fault_set) ? psupc_pkg::SQ_FAIL : psupc_pkg::SQ_OFF;
      seq_cnt_r <= '0;
    end else begin
      case (seq_r)
        psupc_pkg::SQ_OFF, psupc_pkg::SQ_FAIL: begin
          seq_r     <= psupc_pkg::SQ_DELAY;    // request accepted
          seq_cnt_r <= '0;
        end
        psupc_pkg::SQ_DELAY: begin
          if (seq_cnt_r >= `PSUPC_ON_TICKS) begin
            seq_r     <= psupc_pkg::SQ_WREG;
            seq_cnt_r <= '0;
          end else if (tick) begin
            seq_cnt_r <= seq_cnt_r + 1'b1;
          end
        end
        psupc_pkg::SQ_WREG: begin
          if (pin_r[`PSUPC_P_REG]) begin
            seq_r     <= psupc_pkg::SQ_PGW;    // regulation reached
            seq_cnt_r <= '0;
          end else if (seq_cnt_r >= `PSUPC_ON_MAX_TICKS) begin
            seq_r     <= psupc_pkg::SQ_FAIL;
          end else if (tick) begin
            seq_cnt_r <= seq_cnt_r + 1'b1;
          end
        end
        psupc_pkg::SQ_PGW: begin
          if (!pin_r[`PSUPC_P_REG]) begin
            seq_r     <= psupc_pkg::SQ_WREG;   // lost regulation, restart wait
            seq_cnt_r <= '0;
          end else if (seq_cnt_r >= `PSUPC_PG_TICKS) begin
            seq_r     <= psupc_pkg::SQ_ON;
          end else if (tick) begin
            seq_cnt_r <= seq_cnt_r + 1'b1;
          end
        end
        psupc_pkg::SQ_ON: begin
          seq_r <= psupc_pkg::SQ_ON;           // held until run_ok drops: request or input power lost, fault, or software off
        end
        default: begin
          seq_r <= psupc_pkg::SQ_OFF;
        end
      endcase
    end
  end

  // main enable and power good from the sequence
  logic main_nxt;
  logic pg_nxt;
  assign main_nxt = run_ok && (seq_r == psupc_pkg::SQ_WREG || seq_r == psupc_pkg::SQ_PGW ||
                               seq_r == psupc_pkg::SQ_ON);
  assign pg_nxt   = run_ok && (seq_r == psupc_pkg::SQ_ON) && pin_r[`PSUPC_P_REG];
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_main_en  <= 1'b0;
      o_pwr_good <= 1'b0;
    end else begin
      o_main_en  <= main_nxt;
      o_pwr_good <= pg_nxt;
    end
  end

  // alert and amber indicator share one flop
  logic alert_r;
  logic alert_nxt;
  assign alert_nxt = pin_r[`PSUPC_P_WARN] | pin_r[`PSUPC_P_RATE] | pin_r[`PSUPC_P_OPP] |
                     ~ac_ok | fault_r | ctrl_r[`PSUPC_CTRL_FORCE];
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      alert_r <= 1'b0;
    end else begin
      alert_r <= alert_nxt;
    end
  end
  assign o_alert     = 1'b0;     // open drain, only pulls low
  assign o_alert_oe  = alert_r;
  assign o_led_amber = alert_r;

  // strap decode, open pin reads as one
  logic [7:0] rec_addr;
  logic [7:0] mgt_addr;
  logic [7:0] strap_off;
  assign strap_off = {5'h0, pin_r[`PSUPC_P_S1], pin_r[`PSUPC_P_S0], 1'b0};
  assign rec_addr  = `PSUPC_REC_BASE | strap_off;
  assign mgt_addr  = `PSUPC_MGT_BASE | strap_off;

  // bus target: address phase and acknowledge only
  psupc_pkg::psupc_tgt_t tg_r;
  logic       scl_d_r;
  logic       sda_d_r;
  logic [7:0] sh_r;                            // address shift
  logic [3:0] bit_r;                           // bits received
  logic       hit_r;                           // last address matched
  logic       scl_rise;
  logic       scl_fall;
  logic       start_c;
  logic       stop_c;
  logic       match;
  assign scl_rise = pin_r[`PSUPC_P_SCL] & ~scl_d_r;
  assign scl_fall = ~pin_r[`PSUPC_P_SCL] & scl_d_r;
  assign start_c  = pin_r[`PSUPC_P_SCL] & scl_d_r & sda_d_r & ~pin_r[`PSUPC_P_SDA];
  assign stop_c   = pin_r[`PSUPC_P_SCL] & scl_d_r & ~sda_d_r & pin_r[`PSUPC_P_SDA];
  assign match    = (sh_r[7:1] == rec_addr[7:1]) | (sh_r[7:1] == mgt_addr[7:1]);
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tg_r    <= psupc_pkg::TG_IDLE;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      sh_r    <= 8'h00;
      bit_r   <= 4'h0;
      hit_r   <= 1'b0;
    end else begin
      scl_d_r <= pin_r[`PSUPC_P_SCL];
      sda_d_r <= pin_r[`PSUPC_P_SDA];
      if (start_c) begin
        tg_r  <= psupc_pkg::TG_ADDR;           // start or repeated start
        bit_r <= 4'h0;
      end else if (stop_c) begin
        tg_r  <= psupc_pkg::TG_IDLE;
      end else begin
        case (tg_r)
          psupc_pkg::TG_ADDR: begin
            if (scl_rise) begin
              sh_r  <= {sh_r[6:0], pin_r[`PSUPC_P_SDA]};
              bit_r <= bit_r + 4'h1;
            end else if (scl_fall && bit_r == 4'h8) begin
              hit_r <= match;
              tg_r  <= match ? psupc_pkg::TG_ACK : psupc_pkg::TG_SKIP;
            end
          end
          psupc_pkg::TG_ACK: begin
            if (scl_fall) begin
              tg_r <= psupc_pkg::TG_SKIP;      // release after ninth clock
            end
          end
          psupc_pkg::TG_IDLE, psupc_pkg::TG_SKIP: begin
            tg_r <= tg_r;                      // wait for start or stop
          end
          default: begin
            tg_r <= psupc_pkg::TG_IDLE;
          end
        endcase
      end
    end
  end
  assign o_sda    = 1'b0;                              // never drives high
  assign o_sda_oe = (tg_r == psupc_pkg::TG_ACK);

  // ahb address phase capture
  logic       ph_wr_r;
  logic [7:0] ph_addr_r;
  logic       take;
  assign take = hsel & hready & htrans[1];
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ph_wr_r   <= 1'b0;
      ph_addr_r <= 8'h00;
    end else if (hready) begin
      ph_wr_r   <= take & hwrite & (hsize == 3'h2);
      ph_addr_r <= haddr;
    end
  end

  // control register write
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_r <= `PSUPC_CTRL_RST;
    end else if (ph_wr_r && ph_addr_r == `PSUPC_OFF_CTRL) begin
      ctrl_r <= hwdata[1:0];
    end
  end

  // read data, zero on unmapped offsets
  logic [31:0] rd_nxt;
  always_comb begin
    rd_nxt = 32'h0;
    case (haddr)
      `PSUPC_OFF_CTRL:   rd_nxt = {30'h0, ctrl_r};
      `PSUPC_OFF_STATUS: rd_nxt = {20'h0, hit_r, pin_r[`PSUPC_P_S1], pin_r[`PSUPC_P_S0], ac_ok,
                                   alert_r, o_sb_en, o_pwr_good, o_main_en, fault_r, seq_r};
      `PSUPC_OFF_ADDR:   rd_nxt = {16'h0, mgt_addr, rec_addr};
      default:           rd_nxt = 32'h0;
    endcase
  end
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hrdata <= 32'h0;
    end else if (take && !hwrite) begin
      hrdata <= rd_nxt;
    end
  end
  assign hreadyout = 1'b1;  // zero wait states
  assign hresp     = 1'b0;  // always okay

endmodule : psupc_top

// file: tb/psupc_rail_model.sv
// main rail model on the board side: rises after a fast or slow delay
`timescale 1ns/1ns
module psupc_rail_model (
  input  wire logic i_clk,    // bench clock
  input  wire logic i_en,     // main enable from the block
  input  wire logic i_slow,   // pick the slow rise
  output logic      o_in_reg  // rail inside regulation
);
  int rise_r = 0;  // cycles since enable
  // count enabled cycles, restart when the block drops the enable
  always @(posedge i_clk) begin
    rise_r <= i_en ? rise_r + 1 : 0;
  end
  // rail collapses at once when disabled, so no stale in-regulation level
  assign o_in_reg = i_en && (rise_r >= (i_slow ? 300 : 20));
endmodule : psupc_rail_model

// file: tb/psupc_monitor.sv
// concurrent checks on the protection sequencer ports
`timescale 1ns/1ns
module psupc_monitor #(
  parameter int P_MS_CYC = 10  // clock cycles per millisecond tick
) (
  input wire logic i_ref_clk,            // clock
  input wire logic i_rst_n,              // async reset, low active
  input wire logic i_remote_on_input_n,  // on request
  input wire logic i_overcurrent_trip,   // main over limit
  input wire logic i_overpower_trip,     // load above overpower point
  input wire logic i_ac_ok,              // input power present
  input wire logic i_sb_fault,           // standby fault
  input wire logic i_warn,               // warning causes
  input wire logic i_main_in_reg,        // main in regulation
  input wire logic o_main_en,            // main enable
  input wire logic o_sb_en,              // standby enable
  input wire logic o_pwr_good,           // power good
  input wire logic o_alert,              // alert drive value
  input wire logic o_alert_oe,           // alert pull low
  input wire logic o_led_amber           // amber indicator
);
  localparam int C5   = 5 * P_MS_CYC;    // five milliseconds
  localparam int C100 = 100 * P_MS_CYC;  // hundred milliseconds
  int on_cnt_r;   // cycles request held low
  int reg_cnt_r;  // cycles rail in regulation
  int lo_cnt_r;   // cycles power good low
  int oc_cnt_r;   // cycles overcurrent held
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  // run lengths of levels that the timing checks need
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      on_cnt_r  <= 0;
      reg_cnt_r <= 0;
      lo_cnt_r  <= 0;
      oc_cnt_r  <= 0;
    end else begin
      on_cnt_r  <= i_remote_on_input_n ? 0 : on_cnt_r + 1;
      reg_cnt_r <= i_main_in_reg ? reg_cnt_r + 1 : 0;
      lo_cnt_r  <= o_pwr_good ? 0 : lo_cnt_r + 1;
      oc_cnt_r  <= i_overcurrent_trip ? oc_cnt_r + 1 : 0;
    end
  end
  a_main_needs_on: assert property (i_remote_on_input_n [*6] |-> !o_main_en) else $error("main on without request");
  a_main_off_5ms: assert property ($rose(i_remote_on_input_n) |-> ##[1:C5] !o_main_en) else $error("main off late");
  a_pg_off_5ms: assert property ($rose(i_remote_on_input_n) |-> ##[1:C5] !o_pwr_good) else $error("pg drop late");
  a_main_min_delay: assert property ($rose(o_main_en) |-> on_cnt_r >= C5) else $error("main on too soon");
  a_pg_after_reg: assert property ($rose(o_pwr_good) |-> reg_cnt_r >= C100) else $error("pg before regulation");
  a_pg_low_time: assert property ($rose(o_pwr_good) |-> lo_cnt_r >= C100) else $error("pg low too short");
  a_oc_main_off: assert property (oc_cnt_r == 6 * P_MS_CYC |-> !o_main_en) else $error("main on in overcurrent");
  a_sb_short_off: assert property (i_sb_fault [*5] |-> !o_sb_en) else $error("standby on in fault");
  a_sb_auto_back: assert property (!i_sb_fault [*5] |-> o_sb_en) else $error("standby not restored");
  a_warn_alert: assert property (i_warn [*5] |-> o_alert_oe) else $error("no alert on warning");
  a_acloss_alert: assert property (!i_ac_ok [*5] |-> o_alert_oe) else $error("no alert on input loss");
  a_led_with_alert: assert property (o_led_amber == o_alert_oe) else $error("amber and alert differ");
  a_alert_drive: assert property (!o_alert) else $error("alert drives high");
  a_opp_warned: assert property ($fell(o_main_en) && i_overpower_trip |-> $past(o_alert_oe)) else $error("trip before alert");
  c_pg_up: cover property ($rose(o_pwr_good));
  c_alert_up: cover property ($rose(o_alert_oe));
  c_sb_off: cover property ($fell(o_sb_en));
endmodule : psupc_monitor
bind psupc_top psupc_monitor #(.P_MS_CYC(P_MS_CYC)) u_mon (
  .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_remote_on_input_n(i_remote_on_input_n),
  .i_overcurrent_trip(i_overcurrent_trip), .i_overpower_trip(i_overpower_trip), .i_ac_ok(i_ac_ok),
  .i_sb_fault(i_sb_fault), .i_warn(i_warn), .i_main_in_reg(i_main_in_reg), .o_main_en(o_main_en),
  .o_sb_en(o_sb_en), .o_pwr_good(o_pwr_good), .o_alert(o_alert), .o_alert_oe(o_alert_oe),
  .o_led_amber(o_led_amber));

// file: tb/tb.sv
// self-checking bench of the protection sequencer
`timescale 1ns/1ns
`include "psupc_consts.svh"
module tb;
  localparam int MS = 10;  // cycles per tick in simulation
  logic        i_ref_clk = 1'b0, i_rst_n = 1'b0;  // clock and reset
  logic        on_n = 1'b1, scl = 1'b1, sda = 1'b1, sda_drv = 1'b1;  // request and bus wires
  logic [1:0]  strap = 2'h0;  // strap pins
  logic        oc = 1'b0, sc = 1'b0, overpower_trip = 1'b0, above = 1'b0;  // main faults and load
  logic        ac_ok = 1'b1, sb_f = 1'b0, warn = 1'b0, slow = 1'b0;  // input, standby, rail
  logic        in_reg, main_en, sb_en, pg, alert, alert_oe, amber, sda_o, sda_oe;  // observed
  logic        hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;  // ahb controls
  logic [7:0]  haddr = 8'h00;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2, sz = 3'h2;  // size of the next transfer
  logic [31:0] hwdata = 32'h0, hrdata, rd;
  logic        seen;  // sampled bus data
  int          num_errors = 0, check_count = 0, cyc = 0, n;
  wire  [3:0]  obs = {alert_oe, sb_en, pg, main_en};  // waitable outputs
  psupc_top #(.P_MS_CYC(MS)) dut (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_remote_on_input_n(on_n), .i_addr_strap_bit0(strap[0]),
    .i_addr_strap_bit1(strap[1]), .i_scl(scl), .i_sda(sda), .o_sda(sda_o), .o_sda_oe(sda_oe),
    .i_overcurrent_trip(oc), .i_short_circuit_trip(sc), .i_overpower_trip(overpower_trip), .i_above_rating(above),
    .i_ac_ok(ac_ok), .i_sb_fault(sb_f), .i_warn(warn), .i_main_in_reg(in_reg), .o_main_en(main_en),
    .o_sb_en(sb_en), .o_pwr_good(pg), .o_alert(alert), .o_alert_oe(alert_oe), .o_led_amber(amber),
    .hclk_unused_n(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
  psupc_rail_model u_rail (.i_clk(i_ref_clk), .i_en(main_en), .i_slow(slow), .o_in_reg(in_reg));
  // clock
  initial forever #4 i_ref_clk = ~i_ref_clk;
  // bus data wire with pull-up, pulled low by either party
  always @(posedge i_ref_clk) sda <= sda_drv & ~sda_oe;
  // hang guard
  always @(posedge i_ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      num_errors++;
      tally_and_finish;
    end
  end
  task tally_and_finish;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish
  task chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      num_errors++;
      $display("mismatch at %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task tick(input int k);
    repeat (k) @(posedge i_ref_clk);
  endtask : tick
  // one single transfer of size sz, read data taken at the data phase edge
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge i_ref_clk);
    hsel <= 1'b1; htrans <= 2'h2; haddr <= a; hwrite <= w; hsize <= sz;
    do @(posedge i_ref_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
    do @(posedge i_ref_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk(32'(hresp), 32'h0);
  endtask : ahb
  // wait for an output level, cycles taken left in n
  task wt(input int b, input logic v);
    n = 0;
    while (obs[b] !== v && n < 9000) begin
      @(posedge i_ref_clk);
      n++;
    end
    chk(32'(obs[b]), 32'(v));  // a wait that runs out counts as a mismatch
  endtask : wt
  // address byte at 100 kHz, ack looked at mid high of ninth clock, then stop
  task i2c(input logic [7:0] b, input logic ack);
    sda_drv <= 1'b0; tick(625); scl <= 1'b0;
    for (int i = 7; i >= -1; i--) begin
      tick(312); sda_drv <= (i >= 0) ? b[i] : 1'b1; tick(313); scl <= 1'b1;
      tick(312); seen = sda; tick(313); scl <= 1'b0;
    end
    chk(32'(seen), 32'(!ack));
    chk(32'(sda_o), 32'h0);
    tick(312); sda_drv <= 1'b0; tick(313); scl <= 1'b1; tick(625); sda_drv <= 1'b1;
    tick(1250);
  endtask : i2c
  initial begin
    tick(12);
    i_rst_n <= 1'b1;
    tick(4);
    ahb(1'b0, `PSUPC_OFF_CTRL, 32'h0); chk(rd, 32'h0);
    // addresses for every strap setting
    for (int s = 0; s < 4; s++) begin
      strap <= s[1:0]; tick(6);
      ahb(1'b0, `PSUPC_OFF_ADDR, 32'h0); chk(rd, {16'h0, `PSUPC_MGT_BASE + 8'(2 * s), `PSUPC_REC_BASE + 8'(2 * s)});
      ahb(1'b0, `PSUPC_OFF_STATUS, 32'h0); chk(32'(rd[10:9]), 32'(s));
    end
    strap <= 2'h0;
    ahb(1'b0, 8'h0c, 32'h0); chk(rd, 32'h0);
    // a byte-sized write is ignored
    sz <= 3'h0; ahb(1'b1, `PSUPC_OFF_CTRL, 32'h2); sz <= 3'h2;
    ahb(1'b0, `PSUPC_OFF_CTRL, 32'h0); chk(rd, 32'h0);
    i2c(8'ha0, 1'b1);
    i2c(8'h40, 1'b0);
    // plain power on and off
    on_n <= 1'b0; wt(0, 1'b1); chk(32'(n >= 5 * MS && n <= 400 * MS), 32'h1);
    wt(1, 1'b1); chk(32'(n >= 100 * MS && n <= 500 * MS), 32'h1);
    ahb(1'b0, `PSUPC_OFF_STATUS, 32'h0); chk(32'(rd[7:0]), 32'h74);
    on_n <= 1'b1; wt(0, 1'b0); chk(32'(n <= 5 * MS), 32'h1); chk(32'(pg), 32'h0);
    // latched trips: overcurrent cleared by request, short cleared by input loss
    for (int k = 0; k < 2; k++) begin
      slow <= k[0]; on_n <= 1'b0; wt(1, 1'b1);
      if (k == 0) oc <= 1'b1; else sc <= 1'b1;
      tick(8 * MS); oc <= 1'b0; sc <= 1'b0; tick(20 * MS);
      chk(32'(main_en), 32'h0); chk(32'(sb_en), 32'h1);
      ahb(1'b0, `PSUPC_OFF_STATUS, 32'h0); chk(32'(rd[3]), 32'h1);
      if (k == 0) begin
        on_n <= 1'b1; tick(1000 * MS); on_n <= 1'b0;
      end else begin
        ac_ok <= 1'b0; tick(20); ac_ok <= 1'b1;
      end
      wt(0, 1'b1); chk(32'(main_en), 32'h1);
      on_n <= 1'b1; wt(0, 1'b0);
    end
    // overpower: short pulses and quick throttle ride through, sustained trips
    on_n <= 1'b0; wt(1, 1'b1); above <= 1'b1;
    repeat (2) begin
      overpower_trip <= 1'b1; tick(MS); overpower_trip <= 1'b0; tick(99 * MS);
    end
    chk(32'(main_en), 32'h1);
    overpower_trip <= 1'b1; tick(2 * MS); overpower_trip <= 1'b0; above <= 1'b0; tick(5 * MS); chk(32'(main_en), 32'h1);
    above <= 1'b1; overpower_trip <= 1'b1; wt(0, 1'b0); chk(32'(alert_oe), 32'h1);
    overpower_trip <= 1'b0; above <= 1'b0; ac_ok <= 1'b0; tick(20); ac_ok <= 1'b1;
    wt(0, 1'b1); chk(32'(main_en), 32'h1);
    on_n <= 1'b1; wt(0, 1'b0);
    // alert causes one by one
    for (int c = 0; c < 4; c++) begin
      case (c)
        0: warn <= 1'b1;
        1: above <= 1'b1;
        2: ac_ok <= 1'b0;
        default: ahb(1'b1, `PSUPC_OFF_CTRL, 32'h1);
      endcase
      wt(3, 1'b1); chk(32'(n < 4 * MS), 32'h1); chk(32'(amber), 32'h1);
      warn <= 1'b0; above <= 1'b0; ac_ok <= 1'b1;
      if (c == 3) ahb(1'b1, `PSUPC_OFF_CTRL, 32'h0);
      wt(3, 1'b0); chk(32'(alert_oe), 32'h0); chk(32'(amber), 32'h0);
    end
    // standby short held, then removed
    sb_f <= 1'b1; wt(2, 1'b0); tick(200); chk(32'(sb_en), 32'h0);
    sb_f <= 1'b0; wt(2, 1'b1); chk(32'(sb_en), 32'h1);
    tally_and_finish;
  end
endmodule : tb
